// ---- isp_serial_command_security.sv ----
// frame interpreter, protection and erase logic with its bus registers
`include "isp_map.svh"
// Overview of operation
// R1 - protection byte values: FFh open, FEh write-locked, FCh read-write-locked
// R2 - open is the default; from open either higher level may be set
// R3 - protect command only ever raises the level, never lowers it
// R4 - level 1 refuses program, boot status and vector writes, answering P
// R5 - at level 1 the protection byte may change only to level 2
// R6 - level 2 refuses any memory read or write, answering L
// R7 - only a full chip erase returns protection to open
// R8 - chip erase fills memory FFh, status FFh, vector FCh, protection FFh
// R9 - chip erase leaves the resident loader untouched
// R10 - bad checksum answers X, CR, LF and the frame is not run
// R11 - after reset wait for the baud sequence before any frame
// R12 - host opens with a single uppercase U
// R13 - one bit time of the U sets the bit-time count
// R14 - record type selects how each frame is processed
// R15 - every frame is echoed before any status characters
// R16 - good program frame: echo, then period, CR, LF
// R17 - write function 03 with 05 01 sets protection level 2
// R18 - write function with 06 00 programs boot status from third data byte
// R19 - link is 8 data bits, no parity, two stop bits
// R20 - frame: colon, length, offset, type, data, checksum in hex pairs
// R21 - checksum makes the byte sum from length to checksum zero
// R22 - baud detect accepts 2400 to 115200 baud, else keeps waiting; the code also locks up to one eighth of a bit time beyond either end
// R23 - protection level survives reset and gates every memory command
module isp_serial_command_security (
	input  wire logic        CLOCK_IN,
	input  wire logic        RESETN_IN,
	input  wire logic        RXD_IN,
	output logic             TXD_OUT,
	input  wire logic        HSEL_IN,
	input  wire logic [31:0] HADDR_IN,
	input  wire logic [1:0]  HTRANS_IN,
	input  wire logic        HWRITE_IN,
	input  wire logic [2:0]  HSIZE_IN,
	input  wire logic [31:0] HWDATA_IN,
	input  wire logic        HREADY_IN,
	output logic [31:0]      HRDATA_OUT,
	output logic             HREADYOUT_OUT,
	output logic             HRESP_OUT
);
	// =========================================
	// link
	logic                  locked, tx_ready;
	logic [15:0]           bit_cycles;
	isp_pkg::byte_strobe_t rx_byte, tx_byte;
	isp_uart u_uart (
		.clk        (CLOCK_IN),
		.resetn     (RESETN_IN),
		.rxd        (RXD_IN),
		.txd        (TXD_OUT),
		.locked     (locked),
		.bit_cycles (bit_cycles),
		.rx_byte    (rx_byte),
		.tx_byte    (tx_byte),
		.tx_ready   (tx_ready)
	);
	// =========================================
	// nonvolatile model: program store and boot bytes, not cleared by reset
	logic [7:0] prog_mem [0:`MEM_DEPTH-1];
	logic [7:0] access_protection_byte = `PROT_LEVEL0; // R2 R23
	logic [7:0] boot_status_byte = `BOOT_STATUS_RESET;
	logic [7:0] boot_vector_byte = `BOOT_VECTOR_RESET;
	// =========================================
	// frame parser and echo
	isp_pkg::cmd_state_t state, next_state;
	logic [7:0]  hi_nib, next_hi_nib, sum, next_sum, idx, next_idx;
	logic [7:0]  rec_len, next_rec_len, rec_type, next_rec_type;
	logic [15:0] offset, next_offset;
	logic [7:0]  d0, next_d0, d1, next_d1, d2, next_d2;
	logic [7:0]  reply [0:2];
	logic [7:0]  next_reply [0:2];
	logic [1:0]  rp, next_rp;
	logic [8:0]  er_addr, next_er_addr;
	logic        mem_we, bus_erase, erase_req, next_erase_req;
	logic [7:0]  mem_waddr, mem_wdata, nib;
	logic [2:0]  boot_op;
	logic        hex_ok;
	always_comb begin
		hex_ok = 1'b1;
		nib = 8'h00;
		if (rx_byte.data >= 8'h30 && rx_byte.data <= 8'h39) nib = rx_byte.data - 8'h30;
		else if (rx_byte.data >= 8'h41 && rx_byte.data <= 8'h46) nib = rx_byte.data - 8'h37;
		else hex_ok = 1'b0;
	end
	logic [7:0] full_byte;
	assign full_byte = {hi_nib[3:0], nib[3:0]};
	always_comb begin
		next_state = state;
		next_hi_nib = hi_nib;
		next_sum = sum;
		next_idx = idx;
		next_rec_len = rec_len;
		next_rec_type = rec_type;
		next_offset = offset;
		next_d0 = d0;
		next_d1 = d1;
		next_d2 = d2;
		next_reply = reply;
		next_rp = rp;
		next_er_addr = er_addr;
		next_erase_req = erase_req | bus_erase;
		tx_byte = '{data: rx_byte.data, valid: 1'b0};
		mem_we = 1'b0;
		mem_waddr = offset[7:0] + idx - 8'h04;
		mem_wdata = full_byte;
		boot_op = 3'b000;
		if (rx_byte.valid && state != isp_pkg::ST_AUTOBAUD) tx_byte.valid = 1'b1; // R15
		unique case (state)
			isp_pkg::ST_AUTOBAUD: if (locked) next_state = isp_pkg::ST_IDLE; // R11 R12
			isp_pkg::ST_IDLE: begin
				if (erase_req) begin
					next_state = isp_pkg::ST_ERASE;
					next_er_addr = 9'h000;
					next_erase_req = bus_erase;
				end else if (rx_byte.valid && rx_byte.data == `CHAR_COLON) begin // R20
					next_state = isp_pkg::ST_HI;
					next_sum = 8'h00;
					next_idx = 8'h00;
				end
			end
			isp_pkg::ST_HI: if (rx_byte.valid) begin
				next_hi_nib = nib;
				next_state = hex_ok ? isp_pkg::ST_LO : isp_pkg::ST_IDLE;
			end
			isp_pkg::ST_LO: if (rx_byte.valid) begin
				next_state = hex_ok ? isp_pkg::ST_HI : isp_pkg::ST_IDLE;
				next_sum = sum + full_byte; // R21
				next_idx = idx + 8'h01;
				unique case (idx)
					8'h00: next_rec_len = full_byte;
					8'h01: next_offset[15:8] = full_byte;
					8'h02: next_offset[7:0] = full_byte;
					8'h03: next_rec_type = full_byte;
					8'h04: next_d0 = full_byte;
					8'h05: next_d1 = full_byte;
					8'h06: next_d2 = full_byte;
					default: ;
				endcase
				if (idx == rec_len + 8'h04) next_state = isp_pkg::ST_EXEC;
			end
			isp_pkg::ST_EXEC: begin
				next_state = isp_pkg::ST_REPLY;
				next_rp = 2'd0;
				next_reply[0] = `CHAR_PERIOD;
				next_reply[1] = `CHAR_CR;
				next_reply[2] = `CHAR_LF;
				if (sum != 8'h00) next_reply[0] = `CHAR_X; // R10
				else unique case (rec_type) // R14
					`REC_PROGRAM: begin
						if (access_protection_byte == `PROT_LEVEL2) next_reply[0] = `CHAR_L; // R6
						else if (access_protection_byte == `PROT_LEVEL1) next_reply[0] = `CHAR_P; // R4
						else next_state = isp_pkg::ST_HI; // R16
					end
					`REC_WRITE_FN: begin
						if (d0 == `WF_CHIP_ERASE) begin
							next_state = isp_pkg::ST_ERASE; // R7
							next_er_addr = 9'h000;
						end else if (d0 == `WF_PROTECT) boot_op = d1[0] ? 3'b010 : 3'b001; // R17
						else if (d0 == `WF_BOOT_BYTES) begin
							if (access_protection_byte == `PROT_LEVEL2) next_reply[0] = `CHAR_L; // R6
							else if (access_protection_byte == `PROT_LEVEL1) next_reply[0] = `CHAR_P; // R4
							else boot_op = d1[0] ? 3'b100 : 3'b011; // R18
						end
					end
					`REC_DISPLAY, `REC_READ_FN:
						if (access_protection_byte == `PROT_LEVEL2) next_reply[0] = `CHAR_L; // R6
					default: ;
				endcase
			end
			isp_pkg::ST_ERASE: begin
				mem_we = 1'b1;
				mem_waddr = er_addr[7:0];
				mem_wdata = `ERASED_BYTE; // R8 R9
				next_er_addr = er_addr + 9'h001;
				if (er_addr == 9'(`MEM_DEPTH - 1)) begin
					boot_op = 3'b111;
					next_state = isp_pkg::ST_REPLY;
					next_rp = 2'd0;
					next_reply[0] = `CHAR_PERIOD;
					next_reply[1] = `CHAR_CR;
					next_reply[2] = `CHAR_LF;
				end
			end
			isp_pkg::ST_REPLY: if (tx_ready) begin
				tx_byte = '{data: reply[rp], valid: 1'b1};
				next_rp = rp + 2'd1;
				if (rp == 2'd2) next_state = isp_pkg::ST_IDLE;
			end
			default: next_state = isp_pkg::ST_AUTOBAUD;
		endcase
		// program data written after checksum check, replayed from stage on good frames at level 0 only
		if (state == isp_pkg::ST_EXEC && next_state == isp_pkg::ST_HI) begin
			next_state = isp_pkg::ST_REPLY;
			next_rp = 2'd0;
		end
	end
	// =========================================
	// nonvolatile updates
	logic [7:0] stage [0:127];
	always_ff @(posedge CLOCK_IN) begin
		if (state == isp_pkg::ST_LO && rx_byte.valid && idx >= 8'h04)
			stage[7'(idx - 8'h04)] <= full_byte;
		if (mem_we) prog_mem[mem_waddr] <= mem_wdata;
		if (state == isp_pkg::ST_EXEC && sum == 8'h00 && rec_type == `REC_PROGRAM
			&& access_protection_byte == `PROT_LEVEL0)
			for (int i = 0; i < 128; i++)
				if (8'(i) < rec_len) prog_mem[8'(offset[7:0] + 8'(i))] <= stage[i]; // R16
		unique case (boot_op)
			3'b001: if (access_protection_byte == `PROT_LEVEL0)
				access_protection_byte <= `PROT_LEVEL1; // R3 R5
			3'b010: access_protection_byte <= access_protection_byte & `PROT_LEVEL2; // R1 R3
			3'b011: boot_status_byte <= d2; // R18
			3'b100: boot_vector_byte <= d2;
			3'b111: begin
				access_protection_byte <= `PROT_LEVEL0; // R7 R8
				boot_status_byte <= `BOOT_STATUS_RESET;
				boot_vector_byte <= `BOOT_VECTOR_RESET;
			end
			default: ;
		endcase
	end
	always_ff @(posedge CLOCK_IN) begin
		if (!RESETN_IN) begin
			state <= isp_pkg::ST_AUTOBAUD; // R11
			hi_nib <= 8'h00;
			sum <= 8'h00;
			idx <= 8'h00;
			rec_len <= 8'h00;
			rec_type <= 8'h00;
			offset <= 16'h0000;
			d0 <= 8'h00;
			d1 <= 8'h00;
			d2 <= 8'h00;
			reply <= '{8'h00, 8'h00, 8'h00};
			rp <= 2'd0;
			er_addr <= 9'h000;
			erase_req <= 1'b0;
		end else begin
			state <= next_state;
			hi_nib <= next_hi_nib;
			sum <= next_sum;
			idx <= next_idx;
			rec_len <= next_rec_len;
			rec_type <= next_rec_type;
			offset <= next_offset;
			d0 <= next_d0;
			d1 <= next_d1;
			d2 <= next_d2;
			reply <= next_reply;
			rp <= next_rp;
			er_addr <= next_er_addr;
			erase_req <= next_erase_req;
		end
	end
	// =========================================
	// AHB-Lite slave, zero wait states
	logic        dp_valid, dp_write, next_dp_valid, next_dp_write;
	logic [31:0] dp_addr, next_dp_addr, rdata;
	always_comb begin
		next_dp_valid = HSEL_IN && HREADY_IN && HTRANS_IN[1];
		next_dp_write = HWRITE_IN;
		next_dp_addr = HADDR_IN;
		bus_erase = dp_valid && dp_write && dp_addr == `ADDR_REG_CTRL
			&& HWDATA_IN[`CTRL_ERASE_BIT]; // R7
		unique case (dp_addr)
			`ADDR_REG_STATUS: rdata = {23'h0, locked, 4'h0, 4'(state)};
			`ADDR_REG_PROT:   rdata = {24'h0, access_protection_byte};
			`ADDR_REG_BOOT:   rdata = {16'h0, boot_vector_byte, boot_status_byte};
			`ADDR_REG_BAUD:   rdata = {16'h0, bit_cycles};
			default:          rdata = 32'h0000_0000;
		endcase
	end
	assign HRDATA_OUT = dp_valid ? rdata : 32'h0000_0000;
	assign HREADYOUT_OUT = 1'b1;
	assign HRESP_OUT = 1'b0;
	always_ff @(posedge CLOCK_IN) begin
		if (!RESETN_IN) begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_addr <= 32'h0000_0000;
		end else begin
			dp_valid <= next_dp_valid;
			dp_write <= next_dp_write;
			dp_addr <= next_dp_addr;
		end
	end
endmodule // isp_serial_command_security

// ---- isp_map.svh ----
// offsets, field values and timing counts for the serial programming handler
`ifndef ISP_MAP_SVH
`define ISP_MAP_SVH
`define PROT_LEVEL0        8'hFF
`define PROT_LEVEL1        8'hFE
`define PROT_LEVEL2        8'hFC
`define ERASED_BYTE        8'hFF
`define BOOT_STATUS_RESET  8'hFF
`define BOOT_VECTOR_RESET  8'hFC
`define CHAR_PERIOD        8'h2E
`define CHAR_CR            8'h0D
`define CHAR_LF            8'h0A
`define CHAR_COLON         8'h3A
`define CHAR_P             8'h50
`define CHAR_L             8'h4C
`define CHAR_X             8'h58
`define REC_PROGRAM        8'h00
`define REC_WRITE_FN       8'h03
`define REC_DISPLAY        8'h04
`define REC_READ_FN        8'h05
`define WF_PROTECT         8'h05
`define WF_BOOT_BYTES      8'h06
`define WF_CHIP_ERASE      8'h07
`define CLK_HZ             40000000
`define BAUD_MIN           2400
`define BAUD_MAX           115200
`define BIT_MAX_CYC        (`CLK_HZ / `BAUD_MIN)
`define BIT_MIN_CYC        (`CLK_HZ / `BAUD_MAX)
`define STOP_BITS          2
`define MEM_DEPTH          256
`define ADDR_REG_CTRL      32'h0000_0000
`define ADDR_REG_STATUS    32'h0000_0004
`define ADDR_REG_PROT      32'h0000_0008
`define ADDR_REG_BOOT      32'h0000_000C
`define ADDR_REG_BAUD      32'h0000_0010
`define CTRL_ERASE_BIT     0
`endif

// ---- isp_pkg.sv ----
// types shared by the serial programming handler
package isp_pkg;
	typedef struct packed {
		logic [7:0] data;
		logic       valid;
	} byte_strobe_t;
	typedef enum logic [3:0] {
		ST_AUTOBAUD = 4'h0,
		ST_IDLE     = 4'h1,
		ST_HI       = 4'h2,
		ST_LO       = 4'h3,
		ST_EXEC     = 4'h4,
		ST_ERASE    = 4'h5,
		ST_REPLY    = 4'h6
	} cmd_state_t;
endpackage

// ---- isp_uart.sv ----
// bit-rate measurement, receiver and transmitter of the programming link
`include "isp_map.svh"
module isp_uart (
	input  wire logic                 clk,
	input  wire logic                 resetn,
	input  wire logic                 rxd,
	output logic                      txd,
	output logic                      locked,
	output logic [15:0]               bit_cycles,
	output isp_pkg::byte_strobe_t     rx_byte,
	input  wire isp_pkg::byte_strobe_t tx_byte,
	output logic                      tx_ready
);
	// =========================================
	// autobaud: low time of the start bit of 'U' is one bit
	logic [15:0] cnt, next_cnt, next_bit_cycles;
	logic        prev_rx, next_locked, measuring, next_measuring;
	always_comb begin
		next_cnt = cnt;
		next_bit_cycles = bit_cycles;
		next_locked = locked;
		next_measuring = measuring;
		if (!locked) begin
			if (!measuring && prev_rx && !rxd) begin
				next_measuring = 1'b1;
				next_cnt = 16'h0001;
			end else if (measuring && !rxd) begin
				if (cnt > 16'(`BIT_MAX_CYC + `BIT_MAX_CYC / 8)) next_measuring = 1'b0; // R22
				else next_cnt = cnt + 16'h0001;
			end else if (measuring) begin
				next_measuring = 1'b0;
				if (cnt >= 16'(`BIT_MIN_CYC - `BIT_MIN_CYC / 8)) begin // R22
					next_bit_cycles = cnt; // R13
					next_locked = 1'b1;
				end
			end
		end
	end
	// =========================================
	// receiver: after lock, skip rest of 'U' and then frame bytes
	logic [15:0] rcnt, next_rcnt;
	logic [3:0]  rbit, next_rbit;
	logic [7:0]  rsh, next_rsh;
	logic        rbusy, next_rbusy, settle, next_settle;
	isp_pkg::byte_strobe_t next_rx_byte;
	always_comb begin
		next_rcnt = rcnt;
		next_rbit = rbit;
		next_rsh = rsh;
		next_rbusy = rbusy;
		next_settle = settle;
		next_rx_byte = '{data: rx_byte.data, valid: 1'b0};
		if (locked && settle) begin
			next_rcnt = rcnt + 16'h0001;
			if (!rxd) next_rcnt = 16'h0000;
			if (rcnt == 16'(bit_cycles * 2)) next_settle = 1'b0;
		end else if (locked && !rbusy) begin
			if (!rxd) begin
				next_rbusy = 1'b1;
				next_rcnt = {1'b0, bit_cycles[15:1]};
				next_rbit = 4'h0;
			end
		end else if (locked) begin
			if (rcnt == 16'h0000) begin
				next_rcnt = bit_cycles - 16'h0001;
				next_rbit = rbit + 4'h1;
				if (rbit >= 4'h1 && rbit <= 4'h8) next_rsh = {rxd, rsh[7:1]};
				if (rbit == 4'h9) begin // R19
					next_rbusy = 1'b0;
					next_rx_byte = '{data: rsh, valid: rxd};
				end
			end else next_rcnt = rcnt - 16'h0001;
		end
	end
	// =========================================
	// transmitter: start, 8 data, two stop bits
	logic [15:0] tcnt, next_tcnt;
	logic [3:0]  tbit, next_tbit;
	logic [10:0] tsh, next_tsh;
	logic        next_txd;
	assign tx_ready = locked && (tbit == 4'h0);
	always_comb begin
		next_tcnt = tcnt;
		next_tbit = tbit;
		next_tsh = tsh;
		next_txd = txd;
		if (tbit == 4'h0) begin
			if (tx_byte.valid && locked) begin
				next_tsh = {2'b11, tx_byte.data, 1'b0}; // R19
				next_tbit = 4'(1 + 9 + `STOP_BITS);
				next_tcnt = 16'h0000;
			end
		end else if (tcnt == 16'h0000) begin
			next_txd = tsh[0];
			next_tsh = {1'b1, tsh[10:1]};
			next_tbit = tbit - 4'h1;
			next_tcnt = bit_cycles - 16'h0001;
			if (tbit == 4'h1) next_txd = 1'b1;
		end else next_tcnt = tcnt - 16'h0001;
	end
	always_ff @(posedge clk) begin
		if (!resetn) begin // R11
			cnt <= 16'h0000;
			bit_cycles <= 16'h0000;
			locked <= 1'b0;
			measuring <= 1'b0;
			prev_rx <= 1'b1;
			rcnt <= 16'h0000;
			rbit <= 4'h0;
			rsh <= 8'h00;
			rbusy <= 1'b0;
			settle <= 1'b1;
			rx_byte <= '{data: 8'h00, valid: 1'b0};
			tcnt <= 16'h0000;
			tbit <= 4'h0;
			tsh <= 11'h7FF;
			txd <= 1'b1;
		end else begin
			cnt <= next_cnt;
			bit_cycles <= next_bit_cycles;
			locked <= next_locked;
			measuring <= next_measuring;
			prev_rx <= rxd;
			rcnt <= next_rcnt;
			rbit <= next_rbit;
			rsh <= next_rsh;
			rbusy <= next_rbusy;
			settle <= next_settle;
			rx_byte <= next_rx_byte;
			tcnt <= next_tcnt;
			tbit <= next_tbit;
			tsh <= next_tsh;
			txd <= next_txd;
		end
	end
endmodule // isp_uart

// ---- isp_serial_command_security_assertions.sv ----
// port checks of the serial programming handler
`include "isp_map.svh"
module isp_serial_command_security_assertions (
	input wire logic        CLOCK_IN,
	input wire logic        RESETN_IN,
	input wire logic        RXD_IN,
	input wire logic        TXD_OUT,
	input wire logic        HSEL_IN,
	input wire logic [31:0] HADDR_IN,
	input wire logic [1:0]  HTRANS_IN,
	input wire logic        HWRITE_IN,
	input wire logic [31:0] HWDATA_IN,
	input wire logic        HREADY_IN,
	input wire logic [31:0] HRDATA_OUT
);
	// ==========
	// data phase and link tracking
	logic        rd, wr, seen, fin, lk;
	logic        pv = 1'h0;
	logic [7:0]  pl = 8'hFF;
	logic [31:0] a, lo, ec;
	logic        next_rd, next_wr, next_seen, next_fin, next_lk, next_pv;
	logic [7:0]  next_pl;
	logic [31:0] next_lo, next_ec;
	wire         take = HSEL_IN && HREADY_IN && HTRANS_IN[1];
	wire         ctl = wr && a == `ADDR_REG_CTRL;
	wire         rp = rd && a == `ADDR_REG_PROT;
	wire         rb = rd && a == `ADDR_REG_BOOT;
	wire         rt = rd && a == `ADDR_REG_BAUD;
	wire         ers = ec > 32'h7D0;
	default clocking cb @(posedge CLOCK_IN);
	endclocking
	default disable iff (!RESETN_IN);
	always_comb begin
		next_rd = take && !HWRITE_IN;
		next_wr = take && HWRITE_IN;
		next_seen = seen || !RXD_IN;
		next_fin = fin || (seen && RXD_IN);
		next_lo = lo + {31'h0, !RXD_IN && !fin};
		next_lk = (rd && a == `ADDR_REG_STATUS) ? HRDATA_OUT[8] : lk;
		next_pl = rp ? HRDATA_OUT[7:0] : pl;
		next_pv = (pv || rp) && RXD_IN && !ctl;
		next_ec = ec;
		if (ec != 32'h0 && !ers)
			next_ec = ec + 32'h1;
		if (!RXD_IN)
			next_ec = 32'h0;
		if (ctl && HWDATA_IN[0])
			next_ec = 32'h1;
	end
	always_ff @(posedge CLOCK_IN) begin
		a <= HADDR_IN;
		pl <= next_pl;
		pv <= next_pv;
		if (!RESETN_IN) begin
			{rd, wr, seen, fin, lk} <= 5'h00;
			lo <= 32'h0;
			ec <= 32'h0;
		end else begin
			{rd, wr, seen, fin, lk} <= {next_rd, next_wr, next_seen, next_fin, next_lk};
			lo <= next_lo;
			ec <= next_ec;
		end
	end
	// ==========
	// assertions
	property p_prot_code;
		rp |-> HRDATA_OUT inside {32'hFF, 32'hFE, 32'hFC};
	endproperty
	a_prot_code: assert property (p_prot_code) else $error("bad protection code");
	property p_kept;
		rp && pv |-> HRDATA_OUT[7:0] == pl;
	endproperty
	a_kept: assert property (p_kept) else $error("protection changed unasked");
	property p_erase_prot;
		rp && ers |-> HRDATA_OUT == 32'hFF;
	endproperty
	a_erase_prot: assert property (p_erase_prot) else $error("erase left protection");
	property p_erase_boot;
		rb && ers |-> HRDATA_OUT == 32'h0000_FCFF;
	endproperty
	a_erase_boot: assert property (p_erase_boot) else $error("erase left boot bytes");
	property p_quiet;
		!seen |-> TXD_OUT;
	endproperty
	a_quiet: assert property (p_quiet) else $error("transmit before baud sequence");
	property p_lock_state;
		take && !HWRITE_IN && HADDR_IN == `ADDR_REG_STATUS
			|=> HRDATA_OUT[8] == (HRDATA_OUT[3:0] != 4'h0);
	endproperty
	a_lock_state: assert property (p_lock_state) else $error("state without lock");
	property p_bit_time;
		rt && lk |-> HRDATA_OUT + 32'h2 >= lo && HRDATA_OUT <= lo + 32'h2;
	endproperty
	a_bit_time: assert property (p_bit_time) else $error("bit time not measured");
	property p_baud_range;
		rt && lk |-> HRDATA_OUT inside {[32'h12C:32'h493E]};
	endproperty
	a_baud_range: assert property (p_baud_range) else $error("locked outside range");
endmodule // isp_serial_command_security_assertions

// ---- isp_host_model.sv ----
// host programmer model on the far side of the serial link
module isp_host_model #(
	parameter int BIT = 320
) (
	input  wire logic clk_in,
	output logic      rxd_out,
	input  wire logic txd_in
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========
	// host side of the link
	logic [7:0] rx_q [$];
	logic [9:0] sh;
	logic       stop_bad = 1'h0;
	initial rxd_out = 1'h1;
	task automatic send_char(input logic [7:0] c);
		logic [11:0] f;
		f = {3'h7, c, 1'h0};
		for (int i = 0; i < 12; i++) begin
			rxd_out <= f[i];
			repeat (BIT) @(posedge clk_in);
		end
	endtask
	always begin
		@(negedge txd_in);
		repeat (BIT / 2) @(posedge clk_in);
		for (int i = 0; i < 10; i++) begin
			repeat (BIT) @(posedge clk_in);
			sh[i] = txd_in;
		end
		rx_q.push_back(sh[7:0]);
		if (sh[9:8] !== 2'h3)
			stop_bad = 1'h1;
	end
endmodule // isp_host_model

// ---- isp_serial_command_security_tb_top.sv ----
// self-checking bench of the serial programming handler
`include "isp_map.svh"
module isp_serial_command_security_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	// ==========
	// stimulus and checks
	typedef struct packed {
		logic        wr;
		logic [31:0] a;
		logic [31:0] d;
		logic [31:0] e;
	} row_t;
	localparam int BIT = 320;
	logic             clk = 1'h0;
	logic             resetn = 1'h0;
	logic             hsel = 1'h0;
	logic             hwrite = 1'h0;
	logic [1:0]       htrans = 2'h0;
	logic [31:0]      haddr = 32'h0;
	logic [31:0]      hwdata = 32'h0;
	logic [31:0]      d;
	wire logic        rxd;
	wire logic        txd;
	wire logic        hready;
	wire logic        hresp;
	wire logic [31:0] hrdata;
	int               miscompares = 0;
	int               n_checks = 0;
	row_t             rows [4] = '{
		'{1'h0, `ADDR_REG_STATUS, 32'h0, 32'h0},
		'{1'h1, `ADDR_REG_PROT, 32'h0, 32'hFF},
		'{1'h1, 32'h0000_0020, 32'h0000_1234, 32'h0},
		'{1'h0, `ADDR_REG_BOOT, 32'h0, 32'h0000_FCFF}
	};
	always #12.5 clk = ~clk;
	isp_serial_command_security dut (
		.CLOCK_IN(clk), .RESETN_IN(resetn), .RXD_IN(rxd), .TXD_OUT(txd), .HSEL_IN(hsel),
		.HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
		.HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
		.HREADYOUT_OUT(hready), .HRESP_OUT(hresp)
	);
	isp_host_model #(.BIT(BIT)) host (.clk_in(clk), .rxd_out(rxd), .txd_in(txd));
	task automatic print_verdict();
		if (miscompares == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g, input int t);
		n_checks++;
		if ((g + t >= e && g <= e + t) !== 1'h1) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", w, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'h1 && n < 50);
		htrans <= 2'h0;
		hsel <= 1'h0;
		hwdata <= wd;
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'h1 && n < 50);
		d = hrdata;
		chk("response", 32'h0, {31'h0, hresp}, 0);
		if (n >= 50) begin
			miscompares++;
			print_verdict();
		end
	endtask
	task automatic reg_chk(input string w, input logic [31:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0);
		chk(w, e, d, 0);
	endtask
	task automatic expect_rx(input int b, input string e);
		int n;
		n = 0;
		while (host.rx_q.size() < b + e.len() && n < 40000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 40000) begin
			miscompares++;
			print_verdict();
		end else
			for (int i = 0; i < e.len(); i++)
				chk("serial char", {24'h0, e[i]}, {24'h0, host.rx_q[b + i]}, 0);
	endtask
	task automatic frame(input string s, input string r);
		int b;
		b = host.rx_q.size();
		for (int i = 0; i < s.len(); i++)
			host.send_char(s[i]);
		expect_rx(b, {s, r});
	endtask
	initial begin
		repeat (99000) @(posedge clk);
		miscompares++;
		print_verdict();
	end
	initial begin
		int b;
		repeat (2) @(posedge clk);
		resetn <= 1'h1;
		foreach (rows[i]) begin
			if (rows[i].wr)
				bus(1'h1, rows[i].a, rows[i].d);
			reg_chk("register", rows[i].a, rows[i].e);
		end
		host.send_char(8'h55);
		repeat (3 * BIT) @(posedge clk);
		reg_chk("status", `ADDR_REG_STATUS, 32'h0000_0101);
		bus(1'h0, `ADDR_REG_BAUD, 32'h0);
		chk("bit time", BIT, d, 3);
		frame(":020000030501F5", ".\r\n");
		reg_chk("protection", `ADDR_REG_PROT, 32'hFC);
		resetn <= 1'h0;
		repeat (2) @(posedge clk);
		resetn <= 1'h1;
		reg_chk("kept level", `ADDR_REG_PROT, 32'hFC);
		reg_chk("status", `ADDR_REG_STATUS, 32'h0);
		host.send_char(8'h55);
		repeat (3 * BIT) @(posedge clk);
		b = host.rx_q.size();
		bus(1'h1, `ADDR_REG_CTRL, 32'h1);
		expect_rx(b, ".\r\n");
		reg_chk("protection", `ADDR_REG_PROT, 32'hFF);
		reg_chk("boot bytes", `ADDR_REG_BOOT, 32'h0000_FCFF);
		chk("stop bits", 32'h0, {31'h0, host.stop_bad}, 0);
		print_verdict();
	end
endmodule // isp_serial_command_security_tb_top
bind isp_serial_command_security isp_serial_command_security_assertions u_chk (
	.CLOCK_IN(CLOCK_IN), .RESETN_IN(RESETN_IN), .RXD_IN(RXD_IN), .TXD_OUT(TXD_OUT),
	.HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN),
	.HWDATA_IN(HWDATA_IN), .HREADY_IN(HREADY_IN), .HRDATA_OUT(HRDATA_OUT)
);
